// ===== design/twd_defs.svh
// Register offsets, field positions, reset values and keys of the timing and watchdog unit
`ifndef TWD_DEFS_SVH
`define TWD_DEFS_SVH

// ----------------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------------
`define TWD_ADDR_W        24
`define TWD_DATA_W        16

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define TWD_OFS_CONFIG    24'hFFFF20
`define TWD_OFS_PRESCALE  24'hFFFF22
`define TWD_OFS_PRESET    24'hFFFF24
`define TWD_OFS_CTRL      24'hFFFF26
`define TWD_OFS_WD_COUNT  24'hFFFF28
`define TWD_OFS_WD_MATCH  24'hFFFF2A

// ----------------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------------
`define TWD_CFG_LOCK_CFG  0
`define TWD_CFG_LOCK_PRE  1
`define TWD_CFG_LOCK_TMR  2
`define TWD_CFG_LOCK_WDC  3
`define TWD_CFG_WD_CLKSEL 4
`define TWD_CFG_MATCH_EN  5
`define TWD_CFG_RST       6'h00

// ----------------------------------------------------------------------------
// Control and status fields
// ----------------------------------------------------------------------------
`define TWD_CSR_RESTART   0
`define TWD_CSR_TC        1
`define TWD_CSR_INTEN     2

// ----------------------------------------------------------------------------
// Reset values and keys
// ----------------------------------------------------------------------------
`define TWD_PRE_RST       3'h0
`define TWD_PRESET_RST    16'hFFFF
`define TWD_WDC_RST       8'h00
`define TWD_SERVICE_KEY   8'h5C

`endif

// ===== design/twd_pkg.sv
// Types shared by the timing and watchdog unit
package twd_pkg;
  `include "twd_defs.svh"

  typedef enum logic [1:0] {
    PM_ACTIVE = 2'b00,
    PM_PSAVE  = 2'b01,
    PM_IDLE   = 2'b10,
    PM_HALT   = 2'b11
  } twd_pwr_mode_t;

  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_RUN = 2'b01,
    WD_ERR = 2'b10
  } twd_wd_state_t;

  typedef struct packed {
    logic [`TWD_ADDR_W-1:0] addr;
    logic [`TWD_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } twd_bus_req_t;
endpackage : twd_pkg

// ===== design/twd_timer_watchdog.sv
// Timing and watchdog unit: prescaler, periodic timer, watchdog and register port
//
// Summary of operation
// - Slow clock divided by 1, 2, 4, 8, 16 or 32 via a 3-bit field.
// - Periodic timer is a 16-bit down counter stepping on each prescaled tick.
// - At zero the timer reloads from the preset and keeps counting unaided.
// - Reaching zero gives a tick-out pulse of one prescaled period and sets terminal count.
// - Tick-out raises the interrupt only when enabled; also exported for wake-up use.
// - New preset leaves the running count alone; used at the next reload.
// - Restart bit reloads at the next prescaled edge, then clears itself.
// - Watchdog is an 8-bit down counter, idle and silent after reset.
// - Write to count or match register starts it; only reset stops it.
// - Clock select 0 steps watchdog on tick-out, 1 on prescaled tick.
// - Match mode off: count write reloads counter; match writes only start an idle watchdog.
// - Match mode on: writing 5Ch reloads the stored count.
// - Late, too frequent or wrong-key service raises watchdog error and reset.
// - Locked registers ignore writes; reads return zero.
// - Lock bits stay set until reset, including the config lock.
// - Config bits 0..3 lock config, prescaler, timer pair, watchdog count.
// - Outside active mode only the match register is accessible.
// - Counting continues in power save and idle; halt freezes and resumes.
// - Reset clears config; bit 5 match mode, bit 4 clock select.
// - Divisor codes 000..101 give 1..32; other codes reserved.
// - Timer preset resets to FFFFh.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`include "twd_defs.svh"

module twd_timer_watchdog (
  // Clock and reset
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_nrst,
  // Register port
  input  wire twd_pkg::twd_bus_req_t  i_bus,
  output logic [`TWD_DATA_W-1:0]      o_rdata,
  // Slow clock and power mode
  input  wire logic                   i_slow_clk,
  input  wire twd_pkg::twd_pwr_mode_t i_pwr_mode,
  // Events
  output logic                        o_tick_out_pulse,
  output logic                        o_tick_irq,
  output logic                        o_wd_reset
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Reserved codes fall back to the slowest divisor rather than stopping
  function automatic logic [4:0] div_mask(input logic [2:0] code);
    case (code)
      3'h0:    div_mask = 5'h00;
      3'h1:    div_mask = 5'h01;
      3'h2:    div_mask = 5'h03;
      3'h3:    div_mask = 5'h07;
      3'h4:    div_mask = 5'h0F;
      default: div_mask = 5'h1F;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic                  slow_q_ff;
  logic                  slow_en;
  logic                  frozen;
  logic                  active;
  logic [4:0]            pre_cnt_ff;
  logic                  pre_tick;
  logic [5:0]            cfg_ff;
  logic [2:0]            pre_sel_ff;
  logic [15:0]           preset_ff;
  logic                  restart_ff;
  logic                  tc_ff;
  logic                  inten_ff;
  logic [15:0]           tmr_cnt_ff;
  logic                  tick_evt;
  logic                  tick_out_ff;
  logic                  nxt_tick_out;
  logic                  irq_ff;
  twd_pkg::twd_wd_state_t wd_state_ff;
  logic [7:0]            wd_cnt_ff;
  logic [7:0]            wd_reload_ff;
  logic                  served_ff;
  logic                  wd_clk;
  logic                  sel_cfg;
  logic                  sel_pre;
  logic                  sel_tmr;
  logic                  sel_csr;
  logic                  sel_wdc;
  logic                  sel_match;
  logic                  acc_cfg;
  logic                  acc_pre;
  logic                  acc_tmr;
  logic                  acc_wdc;
  logic                  wr_cfg;
  logic                  wr_pre;
  logic                  wr_tmr;
  logic                  wr_csr;
  logic                  wr_wdc;
  logic                  wr_match;
  logic                  match_mode;
  logic                  key_ok;
  logic                  svc;
  logic                  bad_key;
  logic                  wd_late;
  logic                  wd_often;
  logic [`TWD_DATA_W-1:0] nxt_rdata;
  logic [`TWD_DATA_W-1:0] rdata_ff;

  // --------------------------------------------------------------------------
  // Slow clock edge and power mode
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      slow_q_ff <= 1'b0;
    end else begin
      slow_q_ff <= i_slow_clk;
    end
  end

  assign frozen  = (i_pwr_mode == twd_pkg::PM_HALT);
  assign active  = (i_pwr_mode == twd_pkg::PM_ACTIVE);
  // Edges seen during halt are dropped, so counting resumes where it stopped
  assign slow_en = i_slow_clk & ~slow_q_ff & ~frozen;

  // --------------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      pre_cnt_ff <= 5'h00;
    end else if (slow_en) begin
      pre_cnt_ff <= pre_cnt_ff + 5'h01;
    end
  end

  assign pre_tick = slow_en &&
                    ((pre_cnt_ff & div_mask(pre_sel_ff)) == div_mask(pre_sel_ff));

  // --------------------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------------------
  assign sel_cfg   = (i_bus.addr == `TWD_OFS_CONFIG);
  assign sel_pre   = (i_bus.addr == `TWD_OFS_PRESCALE);
  assign sel_tmr   = (i_bus.addr == `TWD_OFS_PRESET);
  assign sel_csr   = (i_bus.addr == `TWD_OFS_CTRL);
  assign sel_wdc   = (i_bus.addr == `TWD_OFS_WD_COUNT);
  assign sel_match = (i_bus.addr == `TWD_OFS_WD_MATCH);

  assign acc_cfg = active & ~cfg_ff[`TWD_CFG_LOCK_CFG];
  assign acc_pre = active & ~cfg_ff[`TWD_CFG_LOCK_PRE];
  assign acc_tmr = active & ~cfg_ff[`TWD_CFG_LOCK_TMR];
  assign acc_wdc = active & ~cfg_ff[`TWD_CFG_LOCK_WDC];

  assign wr_cfg   = i_bus.wr & sel_cfg & acc_cfg;
  assign wr_pre   = i_bus.wr & sel_pre & acc_pre;
  assign wr_tmr   = i_bus.wr & sel_tmr & acc_tmr;
  assign wr_csr   = i_bus.wr & sel_csr & acc_tmr;
  assign wr_wdc   = i_bus.wr & sel_wdc & acc_wdc;
  // Match register stays reachable in every mode so low-power code can service
  assign wr_match = i_bus.wr & sel_match;

  // --------------------------------------------------------------------------
  // Configuration register
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cfg_ff <= `TWD_CFG_RST;
    end else if (wr_cfg) begin
      cfg_ff[5:4] <= i_bus.wdata[5:4];
      cfg_ff[3:0] <= cfg_ff[3:0] | i_bus.wdata[3:0];
    end
  end

  // --------------------------------------------------------------------------
  // Prescaler select and preset
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      pre_sel_ff <= `TWD_PRE_RST;
    end else if (wr_pre) begin
      pre_sel_ff <= i_bus.wdata[2:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      preset_ff <= `TWD_PRESET_RST;
    end else if (wr_tmr) begin
      preset_ff <= i_bus.wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Control and status
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      inten_ff <= 1'b0;
    end else if (wr_csr) begin
      inten_ff <= i_bus.wdata[`TWD_CSR_INTEN];
    end
  end

  // A restart written on a tick edge is kept pending for the following edge
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      restart_ff <= 1'b0;
    end else if (wr_csr && i_bus.wdata[`TWD_CSR_RESTART]) begin
      restart_ff <= 1'b1;
    end else if (pre_tick) begin
      restart_ff <= 1'b0;
    end
  end

  // Terminal count is write-one-to-clear; a new tick wins over the clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      tc_ff <= 1'b0;
    end else if (tick_evt) begin
      tc_ff <= 1'b1;
    end else if (wr_csr && i_bus.wdata[`TWD_CSR_TC]) begin
      tc_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Periodic timer
  // --------------------------------------------------------------------------
  // Zero is held for one tick, so one period is preset plus one ticks
  assign tick_evt = pre_tick && !restart_ff && (tmr_cnt_ff == 16'h0001);

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      tmr_cnt_ff <= `TWD_PRESET_RST;
    end else if (pre_tick) begin
      if (restart_ff || (tmr_cnt_ff == 16'h0000)) begin
        tmr_cnt_ff <= preset_ff;
      end else begin
        tmr_cnt_ff <= tmr_cnt_ff - 16'h0001;
      end
    end
  end

  assign nxt_tick_out = pre_tick ? tick_evt : tick_out_ff;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      tick_out_ff <= 1'b0;
    end else begin
      tick_out_ff <= nxt_tick_out;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_tick_out & inten_ff;
    end
  end

  assign o_tick_out_pulse = tick_out_ff;
  assign o_tick_irq       = irq_ff;

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  assign wd_clk     = cfg_ff[`TWD_CFG_WD_CLKSEL] ? pre_tick : tick_evt;
  assign match_mode = cfg_ff[`TWD_CFG_MATCH_EN];
  assign key_ok     = (i_bus.wdata[7:0] == `TWD_SERVICE_KEY);
  assign svc        = (wr_wdc & ~match_mode) | (wr_match & match_mode & key_ok);
  assign bad_key    = wr_match & match_mode & ~key_ok;
  assign wd_late    = wd_clk && (wd_cnt_ff == 8'h00);
  assign wd_often   = svc && served_ff;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wd_reload_ff <= `TWD_WDC_RST;
    end else if (wr_wdc) begin
      wd_reload_ff <= i_bus.wdata[7:0];
    end
  end

  // Set by a service, cleared by the next watchdog step
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      served_ff <= 1'b0;
    end else if (wd_state_ff == twd_pkg::WD_RUN && svc) begin
      served_ff <= 1'b1;
    end else if (wd_clk) begin
      served_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      wd_state_ff <= twd_pkg::WD_OFF;
      wd_cnt_ff   <= `TWD_WDC_RST;
    end else begin
      unique case (wd_state_ff)
        twd_pkg::WD_OFF: begin
          if (wr_wdc || wr_match) begin
            wd_state_ff <= twd_pkg::WD_RUN;
            wd_cnt_ff   <= wr_wdc ? i_bus.wdata[7:0] : wd_reload_ff;
          end
        end
        twd_pkg::WD_RUN: begin
          if (bad_key || wd_late || wd_often) begin
            wd_state_ff <= twd_pkg::WD_ERR;
          end else if (svc) begin
            wd_cnt_ff <= match_mode ? wd_reload_ff : i_bus.wdata[7:0];
          end else if (wd_clk) begin
            wd_cnt_ff <= wd_cnt_ff - 8'h01;
          end
        end
        twd_pkg::WD_ERR: begin
          wd_state_ff <= twd_pkg::WD_ERR;
        end
        default: begin
          wd_state_ff <= twd_pkg::WD_ERR;
        end
      endcase
    end
  end

  // Held until the device reset arrives, so a slow reset tree cannot miss it
  assign o_wd_reset = (wd_state_ff == twd_pkg::WD_ERR);

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Locked or inaccessible registers read as zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (i_bus.rd) begin
      if (sel_cfg && acc_cfg) begin
        nxt_rdata = {10'h000, cfg_ff};
      end else if (sel_pre && acc_pre) begin
        nxt_rdata = {13'h0000, pre_sel_ff};
      end else if (sel_tmr && acc_tmr) begin
        nxt_rdata = preset_ff;
      end else if (sel_csr && acc_tmr) begin
        nxt_rdata = {13'h0000, inten_ff, tc_ff, restart_ff};
      end else if (sel_wdc && acc_wdc) begin
        nxt_rdata = {8'h00, wd_cnt_ff};
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  a_timer_count_down: assert property (
    pre_tick && !restart_ff && tmr_cnt_ff != 16'h0000
    |=> tmr_cnt_ff == $past(tmr_cnt_ff) - 16'h0001)
    else $error("timer did not step down on tick");

  a_timer_reload: assert property (
    pre_tick && !restart_ff && tmr_cnt_ff == 16'h0000 |=> tmr_cnt_ff == $past(preset_ff))
    else $error("timer did not reload at zero");

  a_tick_sets_tc: assert property (
    tick_evt |=> tc_ff && tick_out_ff && tmr_cnt_ff == 16'h0000)
    else $error("tick did not set flag and pulse");

  a_tick_holds: assert property (
    tick_out_ff && !pre_tick |=> tick_out_ff)
    else $error("tick pulse ended before next prescaled edge");

  a_irq_gated: assert property (
    o_tick_irq |-> $past(inten_ff) && tick_out_ff)
    else $error("interrupt without enable or tick");

  a_preset_quiet: assert property (
    wr_tmr && !pre_tick |=> tmr_cnt_ff == $past(tmr_cnt_ff))
    else $error("preset write disturbed count");

  a_restart_done: assert property (
    pre_tick && restart_ff && !wr_csr |=> !restart_ff && tmr_cnt_ff == $past(preset_ff))
    else $error("restart not taken or not cleared");

  a_wd_stays_off: assert property (
    wd_state_ff == twd_pkg::WD_OFF && !wr_wdc && !wr_match
    |=> wd_state_ff == twd_pkg::WD_OFF && !o_wd_reset)
    else $error("watchdog left idle without a write");

  a_wd_never_stops: assert property (
    wd_state_ff != twd_pkg::WD_OFF |=> wd_state_ff != twd_pkg::WD_OFF)
    else $error("watchdog stopped without reset");

  a_wd_key_reload: assert property (
    wd_state_ff == twd_pkg::WD_RUN && svc && match_mode && !served_ff && !wd_late
    |=> wd_cnt_ff == $past(wd_reload_ff))
    else $error("key service did not reload stored count");

  a_wd_bad_key: assert property (
    wd_state_ff == twd_pkg::WD_RUN && bad_key |=> o_wd_reset [*3])
    else $error("wrong key did not raise watchdog error");

  a_wd_late: assert property (
    wd_state_ff == twd_pkg::WD_RUN && wd_clk && wd_cnt_ff == 8'h00 |=> o_wd_reset)
    else $error("late service not caught");

  a_locked_prescale: assert property (
    cfg_ff[`TWD_CFG_LOCK_PRE] |=> pre_sel_ff == $past(pre_sel_ff))
    else $error("locked prescaler changed");

  a_lock_sticky: assert property (
    (cfg_ff[3:0] & $past(cfg_ff[3:0])) == $past(cfg_ff[3:0]))
    else $error("lock bit cleared");

  a_psave_access: assert property (
    !active && i_bus.wr && sel_tmr |=> preset_ff == $past(preset_ff))
    else $error("preset written outside active mode");

  a_halt_freeze: assert property (
    frozen |=> tmr_cnt_ff == $past(tmr_cnt_ff) && pre_cnt_ff == $past(pre_cnt_ff))
    else $error("counters moved in halt");

  c_tick_irq: cover property (tick_evt && inten_ff);
  c_restart: cover property (pre_tick && restart_ff);
  c_key_service: cover property (wd_state_ff == twd_pkg::WD_RUN && svc && match_mode);
  c_wd_error: cover property ($rose(o_wd_reset));

endmodule // twd_timer_watchdog

// ===== tb/twd_timer_watchdog_tb.sv
// Self-checking bench of the timing and watchdog unit
`timescale 1ns/10ps
`include "twd_defs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end

module twd_timer_watchdog_tb;
  // ----------------------------------------------------------------------------
  // Bench signals
  // ----------------------------------------------------------------------------
  logic                   i_ref_clk   = 1'b0;
  logic                   i_nrst      = 1'b0;
  twd_pkg::twd_bus_req_t  bus         = '0;
  twd_pkg::twd_pwr_mode_t mode        = twd_pkg::PM_ACTIVE;
  logic [1:0]             sc          = 2'h0;
  logic [15:0]            rdata;
  logic                   tick;
  logic                   irq;
  logic                   wd_rst;
  int                     err_total   = 0;
  int                     comparisons = 0;
  int                     cyc         = 0;

  // Slow clock is one quarter of the reference rate
  twd_timer_watchdog u_twd_timer_watchdog (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_bus(bus), .o_rdata(rdata),
    .i_slow_clk(sc[1]), .i_pwr_mode(mode), .o_tick_out_pulse(tick),
    .o_tick_irq(irq), .o_wd_reset(wd_rst));

  always #2 i_ref_clk = ~i_ref_clk;

  always @(posedge i_ref_clk) begin
    sc <= sc + 2'h1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------------
  // Bus and wait tasks
  // ----------------------------------------------------------------------------
  task automatic do_reset();
    i_nrst <= 1'b0;
    mode <= twd_pkg::PM_ACTIVE;
    repeat (12) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    @(posedge i_ref_clk);
  endtask

  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_ref_clk);
    bus.wr <= 1'b0;
    // One idle edge so the next call never re-raises the strobe in this step
    @(posedge i_ref_clk);
  endtask

  task automatic rd(input logic [23:0] a, output logic [15:0] d);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_ref_clk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge i_ref_clk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // Counts reference cycles until the tick-out reaches level v
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (tick !== v && n < 3000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset_vals();
    logic [23:0] adr [7] = '{`TWD_OFS_CONFIG, `TWD_OFS_PRESCALE, `TWD_OFS_PRESET,
      `TWD_OFS_CTRL, `TWD_OFS_WD_COUNT, `TWD_OFS_WD_MATCH, 24'hFFFF2C};
    logic [15:0] ev [7] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000,
      16'h0000, 16'h0000};
    logic [15:0] d;
    for (int i = 0; i < 7; i++) begin
      rd(adr[i], d);
      `CHK("reset value", ev[i], d)
    end
    wr(`TWD_OFS_CONFIG, 16'h0010);
    idle(100);
    `CHK("idle watchdog", 1'b0, wd_rst)
  endtask

  task automatic t_locks();
    logic [15:0] d;
    wr(`TWD_OFS_PRESCALE, 16'h0003);
    wr(`TWD_OFS_CONFIG, 16'h0002);
    wr(`TWD_OFS_PRESCALE, 16'h0005);
    wr(`TWD_OFS_CONFIG, 16'h0000);
    rd(`TWD_OFS_PRESCALE, d);
    `CHK("locked prescaler", 16'h0000, d)
    wr(`TWD_OFS_CONFIG, 16'h0004);
    wr(`TWD_OFS_PRESET, 16'h0007);
    rd(`TWD_OFS_PRESET, d);
    `CHK("locked preset", 16'h0000, d)
    rd(`TWD_OFS_CTRL, d);
    `CHK("locked ctrl", 16'h0000, d)
    // Clock select 0 and a full preset keep the watchdog from stepping here
    wr(`TWD_OFS_WD_COUNT, 16'h0040);
    rd(`TWD_OFS_WD_COUNT, d);
    `CHK("open count", 16'h0040, d)
    wr(`TWD_OFS_CONFIG, 16'h0008);
    rd(`TWD_OFS_WD_COUNT, d);
    `CHK("locked count", 16'h0000, d)
    rd(`TWD_OFS_CONFIG, d);
    `CHK("sticky locks", 16'h000E, d)
    wr(`TWD_OFS_CONFIG, 16'h0001);
    wr(`TWD_OFS_CONFIG, 16'h0000);
    rd(`TWD_OFS_CONFIG, d);
    `CHK("locked config", 16'h0000, d)
  endtask

  task automatic t_timer();
    int a;
    int b;
    logic [15:0] d;
    for (int c = 0; c < 6; c++) begin
      wr(`TWD_OFS_PRESCALE, 16'(c));
      wr(`TWD_OFS_PRESET, 16'h0001);
      wr(`TWD_OFS_CTRL, 16'h0005);
      wait_lvl(1'b1, a);
      `CHK("restart delay", 1'b1, a <= (8 << c) + 4)
      wait_lvl(1'b0, a);
      wait_lvl(1'b1, a);
      wait_lvl(1'b0, a);
      wait_lvl(1'b1, b);
      `CHK("pulse width", 4 << c, a)
      `CHK("period", 8 << c, a + b)
      `CHK("irq enabled", 1'b1, irq)
      rd(`TWD_OFS_CTRL, d);
      `CHK("tc set restart clear", 16'h0006, d)
      wr(`TWD_OFS_CTRL, 16'h0002);
      wait_lvl(1'b0, a);
      wait_lvl(1'b1, a);
      `CHK("irq masked", 1'b0, irq)
    end
  endtask

  task automatic t_preset_change();
    int a;
    int b;
    wr(`TWD_OFS_PRESCALE, 16'h0000);
    wr(`TWD_OFS_PRESET, 16'h0005);
    wr(`TWD_OFS_CTRL, 16'h0001);
    wait_lvl(1'b1, a);
    wait_lvl(1'b0, a);
    // Written just after a reload, so the old count must run out first
    wr(`TWD_OFS_PRESET, 16'h0001);
    wait_lvl(1'b1, b);
    `CHK("running count kept", 20, b + 2)
    wait_lvl(1'b0, a);
    wait_lvl(1'b1, b);
    `CHK("new preset period", 8, a + b)
  endtask

  task automatic t_wd_late();
    logic [15:0] d;
    wr(`TWD_OFS_CONFIG, 16'h0010);
    for (int i = 0; i < 5; i++) begin
      wr(`TWD_OFS_WD_COUNT, 16'h0008);
      idle(15);
    end
    `CHK("timely service", 1'b0, wd_rst)
    wr(`TWD_OFS_WD_COUNT, 16'h0008);
    rd(`TWD_OFS_WD_COUNT, d);
    `CHK("count reload", 1'b1, d >= 16'h0007 && d <= 16'h0008)
    idle(18);
    wr(`TWD_OFS_WD_MATCH, 16'h005C);
    idle(4);
    `CHK("not yet late", 1'b0, wd_rst)
    idle(24);
    `CHK("late service", 1'b1, wd_rst)
  endtask

  task automatic t_wd_often();
    wr(`TWD_OFS_CONFIG, 16'h0000);
    wr(`TWD_OFS_WD_COUNT, 16'h0008);
    wr(`TWD_OFS_WD_COUNT, 16'h0008);
    idle(2);
    `CHK("first service", 1'b0, wd_rst)
    wr(`TWD_OFS_WD_COUNT, 16'h0008);
    idle(2);
    `CHK("too often", 1'b1, wd_rst)
    idle(40);
    `CHK("error held", 1'b1, wd_rst)
  endtask

  task automatic t_wd_match();
    logic [15:0] d;
    wr(`TWD_OFS_CONFIG, 16'h0030);
    wr(`TWD_OFS_WD_COUNT, 16'h0010);
    idle(20);
    rd(`TWD_OFS_WD_COUNT, d);
    `CHK("counting down", 1'b1, d < 16'h0010)
    wr(`TWD_OFS_WD_MATCH, 16'h005C);
    rd(`TWD_OFS_WD_COUNT, d);
    `CHK("key reload", 1'b1, d >= 16'h000F)
    idle(20);
    `CHK("key accepted", 1'b0, wd_rst)
    wr(`TWD_OFS_WD_MATCH, 16'h00A5);
    idle(2);
    `CHK("wrong key", 1'b1, wd_rst)
  endtask

  task automatic t_power();
    logic [15:0] d;
    logic [15:0] c1;
    logic [15:0] c2;
    wr(`TWD_OFS_CONFIG, 16'h0010);
    wr(`TWD_OFS_WD_COUNT, 16'h0050);
    idle(20);
    rd(`TWD_OFS_WD_COUNT, c1);
    mode <= twd_pkg::PM_PSAVE;
    wr(`TWD_OFS_PRESET, 16'h0003);
    rd(`TWD_OFS_PRESET, d);
    `CHK("psave read", 16'h0000, d)
    idle(95);
    mode <= twd_pkg::PM_ACTIVE;
    rd(`TWD_OFS_WD_COUNT, c2);
    `CHK("psave counting", 1'b1, c1 - c2 >= 16'h0018 && c1 - c2 <= 16'h001A)
    rd(`TWD_OFS_PRESET, d);
    `CHK("psave write ignored", 16'hFFFF, d)
    mode <= twd_pkg::PM_HALT;
    idle(600);
    mode <= twd_pkg::PM_ACTIVE;
    rd(`TWD_OFS_WD_COUNT, c1);
    `CHK("halt frozen", 1'b1, c2 - c1 <= 16'h0002)
    `CHK("halt no error", 1'b0, wd_rst)
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    do_reset();
    t_reset_vals();
    t_locks();
    do_reset();
    t_timer();
    t_preset_change();
    do_reset();
    t_wd_late();
    do_reset();
    t_wd_often();
    do_reset();
    t_wd_match();
    do_reset();
    t_power();
    end_of_test();
  end
endmodule // twd_timer_watchdog_tb
